// File: hdl/isd_core.sv
// Module: execute stage for increment-skip, literal OR and register OR
`timescale 1ns/1ps
`default_nettype none
module isd_core (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 insn_valid,
    input  wire logic [11:0]          insn,
    input  wire logic [7:0]           file_rdata,
    output logic [4:0]                file_raddr,
    output isd_pkg::isd_fwrite_t      file_wr,
    output logic [7:0]                acc,
    output logic                      zero_flag,
    output logic                      discard_next,
    output logic                      busy,
    output logic                      done
);
    import isd_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return (v == '0);
    endfunction

    // Instructions that route their result by the destination bit
    function automatic logic uses_dest(input isd_op_t o);
        logic hit;
        hit = 1'b0;
        unique case (o)
            ISD_OP_INCS: hit = 1'b1;
            ISD_OP_ORF:  hit = 1'b1;
            ISD_OP_ORL:  hit = 1'b0;
            ISD_OP_NONE: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Instructions that update the zero flag; increment-skip is not one of them
    function automatic logic sets_zero(input isd_op_t o);
        logic hit;
        hit = 1'b0;
        unique case (o)
            ISD_OP_INCS: hit = 1'b0;
            ISD_OP_ORL:  hit = 1'b1;
            ISD_OP_ORF:  hit = 1'b1;
            ISD_OP_NONE: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    isd_op_t     op;
    isd_state_t  state;
    isd_state_t  next_state;
    logic        take;
    logic        dest;
    logic [4:0]  faddr;
    logic [7:0]  inc_sum;
    logic [7:0]  lit_or;
    logic [7:0]  file_or;
    logic [7:0]  result;
    logic        result_zero;
    logic [7:0]  next_acc;
    logic        next_zero_flag;
    logic        next_discard_next;
    logic        next_busy;
    logic        next_done;
    logic [4:0]  next_file_raddr;
    isd_fwrite_t next_file_wr;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    isd_decode u_decode (
        .insn (insn),
        .op   (op)
    );

    assign dest  = insn[DEST_BIT];
    assign faddr = insn[FADDR_W-1:0];
    // Nothing is accepted in the skip slot
    assign take  = insn_valid && (state == ISD_ST_RUN);

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    assign inc_sum = file_rdata + 8'h01;
    assign lit_or  = acc | insn[DATA_W-1:0];
    assign file_or = acc | file_rdata;

    always_comb begin
        result = '0;
        unique case (op)
            ISD_OP_INCS: begin
                result = inc_sum;
            end
            ISD_OP_ORL: begin
                result = lit_or;
            end
            ISD_OP_ORF: begin
                result = file_or;
            end
            ISD_OP_NONE: begin
                result = '0;
            end
        endcase
    end

    assign result_zero = is_zero(result);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_state        = ISD_ST_RUN;
        next_discard_next = 1'b0;
        next_busy         = 1'b0;
        next_done         = 1'b0;
        unique case (state)
            ISD_ST_SKIP: begin
                // Prefetched word is dropped; this cycle acts as a no-operation
                next_done = 1'b1;
            end
            ISD_ST_RUN: begin
                if (take && op == ISD_OP_INCS && result_zero) begin
                    next_state        = ISD_ST_SKIP;
                    next_discard_next = 1'b1;
                    next_busy         = 1'b1;
                end else if (take && op != ISD_OP_NONE) begin
                    next_done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ISD_ST_RUN;
            discard_next <= 1'b0;
            busy         <= 1'b0;
            done         <= 1'b0;
        end else begin
            state        <= next_state;
            discard_next <= next_discard_next;
            busy         <= next_busy;
            done         <= next_done;
        end
    end

    // ----------------------------------------
    // Accumulator
    // ----------------------------------------
    always_comb begin
        next_acc = acc;
        if (take && op == ISD_OP_ORL) begin
            next_acc = result;
        end else if (take && uses_dest(op) && dest == DEST_ACC) begin
            next_acc = result;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= ACC_RESET;
        end else begin
            acc <= next_acc;
        end
    end

    // ----------------------------------------
    // Zero flag
    // ----------------------------------------
    always_comb begin
        next_zero_flag = zero_flag;
        if (take && sets_zero(op)) begin
            next_zero_flag = result_zero;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_flag <= ZERO_RESET;
        end else begin
            zero_flag <= next_zero_flag;
        end
    end

    // ----------------------------------------
    // Register file write-back
    // ----------------------------------------
    always_comb begin
        next_file_wr = '0;
        if (take && uses_dest(op) && dest == DEST_FILE) begin
            next_file_wr.en   = 1'b1;
            next_file_wr.addr = faddr;
            next_file_wr.data = result;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_wr <= '0;
        end else begin
            file_wr <= next_file_wr;
        end
    end

    // ----------------------------------------
    // Read address echo
    // ----------------------------------------
    always_comb begin
        next_file_raddr = faddr;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_raddr <= '0;
        end else begin
            file_raddr <= next_file_raddr;
        end
    end
endmodule
`default_nettype wire

// File: hdl/isd_decode.sv
// Module: combinational instruction classifier
`timescale 1ns/1ps
`default_nettype none
module isd_decode (
    input  wire logic [11:0]     insn,
    output isd_pkg::isd_op_t     op
);
    import isd_pkg::*;

    always_comb begin
        op = ISD_OP_NONE;
        if (insn[OP6_HI:OP6_LO] == OP_INC_SKIP) begin
            op = ISD_OP_INCS;
        end else if (insn[OP6_HI:OP4_LO] == OP_OR_LIT) begin
            op = ISD_OP_ORL;
        end else if (insn[OP6_HI:OP6_LO] == OP_OR_FILE) begin
            op = ISD_OP_ORF;
        end
    end
endmodule
`default_nettype wire

// File: pkg/isd_pkg.sv
// Package: encodings, field positions, reset values and carriers for the decode/execute block
// What this block does
// - Pattern 001111 in the top six bits increments the addressed file register, writes the destination and leaves every status flag alone.
// - An increment result of zero discards the prefetched next word and runs a no-operation for a second cycle; a nonzero result takes one cycle.
// - Pattern 1101 in the top four bits ORs the accumulator with the low-byte literal in one cycle.
// - The literal OR writes its result to the accumulator and updates the zero flag from it.
// - Pattern 000100 in the top six bits ORs the accumulator with the addressed file register, writes the destination and updates the zero flag in one cycle.
// - For increment-skip and register OR, destination bit 0 selects the accumulator and 1 the addressed file register.
package isd_pkg;
    localparam int          INSN_W       = 12;
    localparam int          DATA_W       = 8;
    localparam int          FADDR_W      = 5;
    localparam int          DEST_BIT     = 5;
    localparam int          OP6_HI       = 11;
    localparam int          OP6_LO       = 6;
    localparam int          OP4_LO       = 8;
    localparam logic [5:0]  OP_INC_SKIP  = 6'h0f;
    localparam logic [5:0]  OP_OR_FILE   = 6'h04;
    localparam logic [3:0]  OP_OR_LIT    = 4'hd;
    localparam logic        DEST_ACC     = 1'h0;
    localparam logic        DEST_FILE    = 1'h1;
    localparam logic [7:0]  ACC_RESET    = 8'h00;
    localparam logic        ZERO_RESET   = 1'h0;
    localparam logic [11:0] INSN_NOP     = 12'h000;

    typedef enum logic [1:0] {
        ISD_OP_NONE = 2'b00,
        ISD_OP_INCS = 2'b01,
        ISD_OP_ORL  = 2'b10,
        ISD_OP_ORF  = 2'b11
    } isd_op_t;

    typedef enum logic [0:0] {
        ISD_ST_RUN  = 1'b0,
        ISD_ST_SKIP = 1'b1
    } isd_state_t;

    // Write-back request towards the register file
    typedef struct packed {
        logic               en;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
    } isd_fwrite_t;
endpackage

// File: tb/isd_core_assertions.sv
// Checker: concurrent assertions on the decode/execute block
`timescale 1ns/1ps
`default_nettype none
module isd_core_assertions (
    input wire logic                 ref_clk,
    input wire logic                 rst_n,
    input wire logic                 insn_valid,
    input wire logic [11:0]          insn,
    input wire logic [7:0]           file_rdata,
    input wire isd_pkg::isd_fwrite_t file_wr,
    input wire logic [7:0]           acc,
    input wire logic                 zero_flag,
    input wire logic                 discard_next,
    input wire logic                 busy,
    input wire logic                 done
);
    import isd_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic       tk     = insn_valid && !busy;
    wire logic       inc    = tk && insn[11:6] == OP_INC_SKIP;
    wire logic       orf    = tk && insn[11:6] == OP_OR_FILE;
    wire logic       orl    = tk && insn[11:8] == OP_OR_LIT;
    wire logic       dsel   = insn[5];
    wire logic [4:0] fsel   = insn[4:0];
    wire logic [7:0] or_res = acc | (orl ? insn[7:0] : file_rdata);
    a_inc_write: assert property (inc && insn[5] |=> file_wr.en &&
        file_wr.addr == $past(fsel) &&
        file_wr.data == $past(file_rdata) + 8'h01) else $error("inc write");
    a_inc_acc: assert property (inc && !insn[5] |=> !file_wr.en &&
        acc == $past(file_rdata) + 8'h01) else $error("inc acc");
    a_inc_flags: assert property (inc |=> $stable(zero_flag)) else $error("inc z");
    a_skip_two: assert property (inc && file_rdata == 8'hff |=>
        discard_next && busy && !done ##1 done && !busy) else $error("skip");
    a_no_skip: assert property (inc && file_rdata != 8'hff |=>
        done && !discard_next && !busy) else $error("no skip");
    a_lit_or: assert property (orl |=> done &&
        acc == $past(or_res)) else $error("lit or");
    a_zero_set: assert property (orl || orf |=> zero_flag ==
        ($past(or_res) == 8'h00)) else $error("z");
    a_orf_dest: assert property (orf |=> done && file_wr.en == $past(dsel) &&
        (file_wr.en ? file_wr.data : acc) == $past(or_res)) else $error("orf");
    a_skip_refuse: assert property (busy |=> done && !busy && !discard_next &&
        !file_wr.en && $stable(acc) && $stable(zero_flag)) else $error("skip slot taken");
endmodule
bind isd_core isd_core_assertions u_chk (.ref_clk, .rst_n, .insn_valid, .insn,
    .file_rdata, .file_wr, .acc, .zero_flag, .discard_next, .busy, .done);
`default_nettype wire

// File: tb/isd_core_test.sv
// Testbench: random and corner instruction streams for the decode/execute block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module isd_core_test;
    import isd_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        insn_valid = 1'b0;
    logic [11:0] insn = 12'h000;
    logic [7:0]  file_rdata = 8'h00;
    isd_fwrite_t file_wr;
    logic [7:0]  acc;
    logic [4:0]  file_raddr;
    logic        zero_flag, discard_next, busy, done;
    logic [7:0]  m_acc = 8'h00;
    logic        m_z = 1'b0;
    int          err_total = 0, checks_done = 0, cyc = 0, seed = 74362, r;
    always #20 ref_clk = ~ref_clk;
    isd_core u_isd_core (.ref_clk, .rst_n, .insn_valid, .insn, .file_rdata,
        .file_raddr, .file_wr, .acc, .zero_flag, .discard_next, .busy, .done);
    function automatic logic [7:0] exp_res(logic [11:0] i, logic [7:0] a, logic [7:0] rd);
        return i[11:6] == OP_INC_SKIP ? rd + 8'h01 : (i[11:8] == OP_OR_LIT ? a | i[7:0] : a | rd);
    endfunction
    task automatic final_report;
        if (err_total == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic run(logic [11:0] i, logic [7:0] rd);
        logic inc, orl, orf, wr, skip;
        logic [7:0] res;
        inc = i[11:6] == OP_INC_SKIP;
        orl = i[11:8] == OP_OR_LIT;
        orf = i[11:6] == OP_OR_FILE;
        res = exp_res(i, m_acc, rd);
        skip = inc && res == 8'h00;
        wr = (inc || orf) && i[5] == DEST_FILE;
        @(posedge ref_clk);
        insn_valid <= 1'b1;
        insn <= i;
        file_rdata <= rd;
        @(posedge ref_clk);
        // Offered in the skip slot, must be refused
        insn_valid <= skip;
        insn <= {OP_OR_LIT, 8'hff};
        if ((inc || orl || orf) && !wr) m_acc = res;
        if (orl || orf) m_z = res == 8'h00;
        #1;
        `CHK("done", !skip && (inc || orl || orf), done)
        `CHK("skip", skip, {discard_next, busy} == 2'b11)
        `CHK("acc", m_acc, acc)
        `CHK("zero", m_z, zero_flag)
        `CHK("wr_en", wr, file_wr.en)
        `CHK("raddr", i[4:0], file_raddr)
        if (wr) `CHK("wr", {i[4:0], res}, {file_wr.addr, file_wr.data})
        if (skip) begin
            @(posedge ref_clk);
            insn_valid <= 1'b0;
            #1;
            `CHK("slot", {1'b1, m_acc}, {done, acc})
        end
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        run(12'hd00, 8'h00);
        run(12'h3c0, 8'h99);
        run(12'hd35, 8'h00);
        run(12'h3e5, 8'hff);
        run(12'h125, 8'h40);
        run(12'h105, 8'h00);
        run(12'h800, 8'h00);
        // Reset in mid-run, then a zero result from the register OR
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK("rst_acc", {ACC_RESET, ZERO_RESET}, {acc, zero_flag})
        `CHK("rst_out", 4'h0, {discard_next, busy, done, file_wr.en})
        m_acc = ACC_RESET;
        m_z = ZERO_RESET;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        run(12'h100, 8'h00);
        run(12'h3c0, 8'hff);
        run(12'h13f, 8'h00);
        repeat (400) begin
            r = $random(seed);
            run(r[1:0] == 2'd0 ? {OP_INC_SKIP, r[9:4]} : r[1:0] == 2'd1 ? {OP_OR_LIT, r[11:4]}
                : r[1:0] == 2'd2 ? {OP_OR_FILE, r[9:4]} : {4'h8, r[11:4]},
                r[3:2] == 2'd0 ? 8'hff : r[19:12]);
        end
        final_report;
    end
endmodule
`default_nettype wire
